// ==== rtl/svr_repair.sv ====
`timescale 1ns/10ps
module svr_repair #(
  parameter int DEPTH = svr_pkg::MEM_DEPTH,
  parameter int HDR_LEN = svr_pkg::HDR_LEN
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic zero_skip_mode,
  input wire logic in_valid,
  output logic in_ready,
  input wire svr_pkg::svr_beat_t in_beat,
  output logic out_valid,
  input wire logic out_ready,
  output svr_pkg::svr_beat_t out_beat,
  output svr_pkg::svr_report_t report
);

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] HDR_P = PW'(HDR_LEN);
  localparam logic [PW-1:0] SVC_P = PW'(svr_pkg::SERVICE_LEN);
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
  localparam logic [PW-1:0] ONE_P = PW'(1);

  // Storage must be 48 to 256 bytes and hold the header plus the 35 service bytes
  if (DEPTH < svr_pkg::MIN_CAPTURE || DEPTH > 256 || HDR_LEN < 2 ||
      HDR_LEN + svr_pkg::SERVICE_LEN > DEPTH) begin : g_chk
    $error("svr_repair: DEPTH or HDR_LEN out of range");
  end

  typedef enum logic [2:0] {
    ST_CAP,
    ST_CHECK,
    ST_SCAN_RD,
    ST_SCAN_CHK,
    ST_RD,
    ST_LOAD,
    ST_HOLD
  } svr_state_t;

  svr_state_t state_r;
  svr_state_t state_nxt;
  logic [PW-1:0] len_r;
  logic overflow_r;
  logic [7:0] count_byte_r;
  logic mode_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW-1:0] beg_ptr_r;
  logic [PW-1:0] end_ptr_r;
  logic [7:0] rd_data;
  logic [5:0] cnt;
  logic [5:0] excess;
  logic cnt_good;
  logic cnt_nominal;
  logic wr_fire;
  logic [AW-1:0] wr_addr;
  logic wr_en;
  logic [PW-1:0] start_ptr;
  logic fits;
  logic pass_through;
  logic scan_hit;
  logic scan_fits;
  logic scan_end;
  logic out_fire;

  svr_pkt_mem #(
    .WIDTH(svr_pkg::BYTE_W),
    .DEPTH(DEPTH)
  ) u_mem (
    .clock(clock),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(in_beat.data),
    .rd_addr(rd_ptr_r[AW-1:0]),
    .rd_data(rd_data)
  );

  svr_count_check u_cc (
    .raw(count_byte_r),
    .count(cnt),
    .excess(excess),
    .good(cnt_good),
    .nominal(cnt_nominal)
  );

  // Input accepted only while capturing; stalls the source otherwise
  assign in_ready = state_r == ST_CAP;
  assign wr_fire = in_valid && in_ready;
  assign wr_addr = in_beat.first ? '0 : len_r[AW-1:0];
  assign wr_en = wr_fire && (in_beat.first || len_r < DEPTH_P);
  assign out_fire = out_valid && out_ready;

  // Count-driven window: header plus excess, then 35 service bytes
  always_comb begin
    start_ptr = HDR_P + PW'(excess);
    fits = (start_ptr + SVC_P) <= len_r;
    pass_through = !cnt_good || overflow_r || !fits;
  end

  // Zero-skip scan decisions on the byte just read
  always_comb begin
    scan_hit = rd_data != 8'h00;
    scan_fits = (rd_ptr_r + SVC_P) <= len_r;
    scan_end = (rd_ptr_r + ONE_P) >= len_r;
  end

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_CAP: begin
        if (wr_fire && in_beat.last) begin
          state_nxt = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (mode_r && !overflow_r) begin
          state_nxt = ST_SCAN_RD;
        end else begin
          state_nxt = ST_RD;
        end
      end
      ST_SCAN_RD: begin
        state_nxt = ST_SCAN_CHK;
      end
      ST_SCAN_CHK: begin
        if (scan_hit || scan_end) begin
          state_nxt = ST_RD;
        end else begin
          state_nxt = ST_SCAN_RD;
        end
      end
      ST_RD: begin
        state_nxt = ST_LOAD;
      end
      ST_LOAD: begin
        state_nxt = ST_HOLD;
      end
      ST_HOLD: begin
        if (out_fire) begin
          state_nxt = out_beat.last ? ST_CAP : ST_RD;
        end
      end
      default: begin
        state_nxt = ST_CAP;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= ST_CAP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Byte count of the stored packet and overflow tracking
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      len_r <= '0;
      overflow_r <= 1'b0;
    end else if (wr_fire) begin
      if (in_beat.first) begin
        len_r <= ONE_P;
        overflow_r <= 1'b0;
      end else if (len_r < DEPTH_P) begin
        len_r <= len_r + ONE_P;
      end else begin
        overflow_r <= 1'b1;
      end
    end
  end

  // Count byte and mode caught with the final byte
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_byte_r <= svr_pkg::DATA_RST;
      mode_r <= 1'b0;
    end else if (wr_fire && in_beat.last) begin
      count_byte_r <= in_beat.data;
      mode_r <= zero_skip_mode;
    end
  end

  // Read window pointers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_ptr_r <= '0;
      beg_ptr_r <= '0;
      end_ptr_r <= '0;
    end else begin
      case (state_r)
        ST_CHECK: begin
          if (mode_r && !overflow_r) begin
            rd_ptr_r <= HDR_P;
          end else if (pass_through) begin
            rd_ptr_r <= '0;
            beg_ptr_r <= '0;
            end_ptr_r <= len_r;
          end else begin
            rd_ptr_r <= start_ptr;
            beg_ptr_r <= start_ptr;
            end_ptr_r <= start_ptr + SVC_P;
          end
        end
        ST_SCAN_CHK: begin
          if (scan_hit && scan_fits) begin
            beg_ptr_r <= rd_ptr_r;
            end_ptr_r <= rd_ptr_r + SVC_P;
          end else if (scan_hit || scan_end) begin
            rd_ptr_r <= '0;
            beg_ptr_r <= '0;
            end_ptr_r <= len_r;
          end else begin
            rd_ptr_r <= rd_ptr_r + ONE_P;
          end
        end
        ST_HOLD: begin
          if (out_fire && !out_beat.last) begin
            rd_ptr_r <= rd_ptr_r + ONE_P;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Output byte register with valid/ready hold
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_beat <= '0;
    end else if (state_r == ST_LOAD) begin
      out_valid <= 1'b1;
      out_beat.data <= rd_data;
      out_beat.first <= rd_ptr_r == beg_ptr_r;
      out_beat.last <= (rd_ptr_r + ONE_P) == end_ptr_r;
    end else if (out_fire) begin
      out_valid <= 1'b0;
    end
  end

  // Per-packet outcome pulse
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      report <= '0;
    end else begin
      report <= '0;
      if (state_r == ST_CHECK && !(mode_r && !overflow_r)) begin
        report.error <= pass_through;
        report.repaired <= !pass_through && !cnt_nominal;
        report.removed <= pass_through ?
                          svr_pkg::REMOVED_RST : 8'(excess);
      end else if (state_r == ST_SCAN_CHK && (scan_hit || scan_end)) begin
        report.error <= !(scan_hit && scan_fits);
        report.repaired <= scan_hit && scan_fits &&
                           rd_ptr_r != HDR_P;
        report.removed <= (scan_hit && scan_fits) ?
                          8'(rd_ptr_r - HDR_P) :
                          svr_pkg::REMOVED_RST;
      end
    end
  end

endmodule

// ==== pkg/svr_pkg.sv ====
package svr_pkg;

  // Count byte layout
  localparam int CNT_LSB = 0;
  localparam int CNT_MSB = 5;
  localparam int FIX_BIT = 6;
  localparam int PAR_BIT = 7;
  localparam int CNT_W = 6;

  // Packet geometry
  localparam logic [5:0] NOMINAL_COUNT = 6'h25;
  localparam logic [7:0] NOMINAL_RAW = 8'h25;
  localparam int SERVICE_LEN = 35;
  localparam int HDR_LEN = 8;
  localparam int MIN_CAPTURE = 48;
  localparam int MEM_DEPTH = 64;
  localparam int BYTE_W = 8;
  localparam int REMOVED_W = 8;

  // Values after reset
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] REMOVED_RST = 8'h00;

  // One byte of a packet stream
  typedef struct packed {
    logic first;
    logic last;
    logic [7:0] data;
  } svr_beat_t;

  // Per-packet outcome, one-cycle pulses
  typedef struct packed {
    logic repaired;
    logic error;
    logic [7:0] removed;
  } svr_report_t;

endpackage

// ==== rtl/svr_pkt_mem.sv ====
`timescale 1ns/10ps
module svr_pkt_mem #(
  parameter int WIDTH = svr_pkg::BYTE_W,
  parameter int DEPTH = svr_pkg::MEM_DEPTH
) (
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH < 2 || WIDTH < 1) begin : g_chk
    $error("svr_pkt_mem: bad geometry");
  end

  // Write port
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read, one cycle latency
  always_ff @(posedge clock) begin
    rd_data <= mem[rd_addr];
  end

endmodule

// ==== rtl/svr_count_check.sv ====
`timescale 1ns/10ps
module svr_count_check (
  input wire logic [7:0] raw,
  output logic [5:0] count,
  output logic [5:0] excess,
  output logic good,
  output logic nominal
);

  logic parity_ok;
  logic fix_ok;
  logic not_short;

  // Field split and sanity checks
  always_comb begin
    count = raw[svr_pkg::CNT_MSB:svr_pkg::CNT_LSB];
    parity_ok = ^raw;
    fix_ok = !raw[svr_pkg::FIX_BIT];
    not_short = count >= svr_pkg::NOMINAL_COUNT;
    good = parity_ok && fix_ok && not_short;
    nominal = raw == svr_pkg::NOMINAL_RAW;
    excess = not_short ? count - svr_pkg::NOMINAL_COUNT : 6'h00;
  end

endmodule

// ==== bench/svr_repair_monitor.sv ====
`timescale 1ns/10ps
module svr_repair_monitor #(
  parameter int DEPTH = svr_pkg::MEM_DEPTH,
  parameter int HDR_LEN = svr_pkg::HDR_LEN
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic zero_skip_mode,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire svr_pkg::svr_beat_t in_beat,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire svr_pkg::svr_beat_t out_beat,
  input wire svr_pkg::svr_report_t report
);
  logic [7:0] cnt_r;
  logic zs_r;
  logic end_in;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Count-mode packet end
  assign end_in = in_valid && in_ready && in_beat.last && !zero_skip_mode;
  // Holds count byte and mode of the packet in flight
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r <= 8'h00;
      zs_r <= 1'b0;
    end else if (in_valid && in_ready && in_beat.last) begin
      cnt_r <= in_beat.data;
      zs_r <= zero_skip_mode;
    end
  end
  a_out_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_beat))
    else $error("output byte changed while stalled");
  a_ready_out: assert property (
    out_valid |-> !in_ready)
    else $error("capture open during output");
  a_err_clean: assert property (
    report.error |-> !report.repaired && report.removed == 8'h00)
    else $error("error report not clean");
  a_pulse_once: assert property (
    report.error || report.repaired
    |=> !(report.error || report.repaired))
    else $error("report longer than one cycle");
  a_first_byte: assert property (
    end_in |-> ##[4:5] (out_valid && out_beat.first))
    else $error("first output byte late");
  a_nominal_clean: assert property (
    end_in && in_beat.data == svr_pkg::NOMINAL_RAW
    |=> (!report.repaired && !report.error) [*4])
    else $error("nominal packet flagged");
  a_bad_code: assert property (
    end_in && (!(^in_beat.data) || in_beat.data[svr_pkg::FIX_BIT] ||
    in_beat.data[5:0] < svr_pkg::NOMINAL_COUNT) |-> ##[1:3] report.error)
    else $error("bad count byte not flagged");
  a_removed_cnt: assert property (
    report.repaired && !zs_r
    |-> report.removed == {2'h0, cnt_r[5:0] - svr_pkg::NOMINAL_COUNT})
    else $error("wrong removed count");
endmodule
bind svr_repair svr_repair_monitor #(.DEPTH(DEPTH), .HDR_LEN(HDR_LEN)) mon (
  .clock(clock), .rst(rst), .zero_skip_mode(zero_skip_mode),
  .in_valid(in_valid), .in_ready(in_ready), .in_beat(in_beat),
  .out_valid(out_valid), .out_ready(out_ready), .out_beat(out_beat),
  .report(report));

// ==== bench/svr_src.sv ====
`timescale 1ns/10ps
module svr_src (
  input wire logic clock,
  input wire logic in_ready,
  output logic in_valid,
  output svr_pkg::svr_beat_t in_beat
);
  logic [7:0] mem [64];
  // Idle at time zero
  initial begin
    in_valid = 1'b0;
    in_beat = '0;
  end
  // Offers one whole packet, count byte last
  task automatic send(input int n, input logic slow);
    for (int i = 0; i < n; i++) begin
      if (slow && i[0]) begin
        in_valid <= 1'b0;
        in_beat.data <= ~mem[i-1];
        @(posedge clock);
      end
      in_valid <= 1'b1;
      in_beat <= '{first: i == 0, last: i == n - 1,
                   data: mem[i]};
      @(negedge clock);
      while (!in_ready) @(negedge clock);
      @(posedge clock);
    end
    in_valid <= 1'b0;
    in_beat <= '{first: 1'b0, last: 1'b0, data: ~mem[n-1]};
  endtask
endmodule

// ==== bench/svr_repair_tb.sv ====
`timescale 1ns/10ps
module svr_repair_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic zero_skip_mode = 1'b0;
  logic out_ready = 1'b0;
  logic in_valid;
  logic in_ready;
  logic out_valid;
  svr_pkg::svr_beat_t in_beat;
  svr_pkg::svr_beat_t out_beat;
  svr_pkg::svr_report_t report;
  svr_pkg::svr_report_t rep_q;
  logic [7:0] got [$];
  logic [7:0] exp [$];
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  svr_repair uut (.clock(clock), .rst(rst), .zero_skip_mode(zero_skip_mode),
    .in_valid(in_valid), .in_ready(in_ready), .in_beat(in_beat),
    .out_valid(out_valid), .out_ready(out_ready), .out_beat(out_beat),
    .report(report));
  svr_src src (.clock(clock), .in_ready(in_ready), .in_valid(in_valid),
    .in_beat(in_beat));
  always #20 clock = ~clock;
  // Stalling sink, report capture and timeout
  always @(posedge clock) begin
    cyc++;
    out_ready <= (cyc % 5) != 0;
    if (out_valid && out_ready) got.push_back(out_beat.data);
    if (report.repaired || report.error) rep_q <= report;
    if (cyc == 12000) begin
      err_count++;
      results;
    end
  end
  task automatic check8(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t byte %h expected %h", $time, g, e);
    end
  endtask
  task automatic check_rep(input svr_pkg::svr_report_t g,
                           input svr_pkg::svr_report_t e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t report %h expected %h", $time, g, e);
    end
  endtask
  // One 52-byte packet: header, k zero bytes, service, count byte
  task automatic run(input int k, input logic [7:0] cb, input logic zs,
                     input logic bad, input logic slow);
    svr_pkg::svr_report_t want;
    want = '{repaired: k > 0 && !bad, error: bad,
             removed: bad ? 8'h00 : 8'(k)};
    exp.delete();
    got.delete();
    rep_q = '0;
    for (int i = 0; i < 52; i++) begin
      src.mem[i] = i == 51 ? cb : i < 8 ? 8'h10 + 8'(i) :
                   i < 8 + k ? 8'h00 : 8'h40 + 8'(i);
      if (bad || (i >= 8 + k && i < 43 + k)) exp.push_back(src.mem[i]);
    end
    zero_skip_mode <= zs;
    @(posedge clock);
    src.send(52, slow);
    for (int t = 0; t < 4000 && got.size() < exp.size(); t++)
      @(posedge clock);
    repeat (8) @(posedge clock);
    check_rep(rep_q, want);
    check8(8'(got.size()), 8'(exp.size()));
    foreach (exp[i]) check8(got[i], exp[i]);
  endtask
  task automatic t_nominal;
    run(0, 8'h25, 1'b0, 1'b0, 1'b1);
    $display("t_nominal done");
  endtask
  task automatic t_insert;
    run(2, 8'ha7, 1'b0, 1'b0, 1'b0);
    run(3, 8'ha8, 1'b0, 1'b0, 1'b1);
    run(4, 8'h29, 1'b0, 1'b0, 1'b0);
    $display("t_insert done");
  endtask
  task automatic t_bad;
    run(0, 8'ha5, 1'b0, 1'b1, 1'b0);
    run(0, 8'he5, 1'b0, 1'b1, 1'b0);
    run(0, 8'ha4, 1'b0, 1'b1, 1'b0);
    run(0, 8'hbf, 1'b0, 1'b1, 1'b0);
    $display("t_bad done");
  endtask
  task automatic t_zero_skip;
    run(3, 8'h25, 1'b1, 1'b0, 1'b0);
    run(0, 8'ha7, 1'b1, 1'b0, 1'b1);
    run(12, 8'h25, 1'b1, 1'b1, 1'b0);
    $display("t_zero_skip done");
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_nominal;
    t_insert;
    t_bad;
    t_zero_skip;
    results;
  end
endmodule
